// file: rtl/vap_ctrl.sv
// Our own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - single vector mode: high vector is the table base itself
// - single vector with priorities: low vector is base plus eight words
// - base resets to 000008h, giving vectors 000008h and 000018h
// - multi vector mode: vector is base plus twice the vector number
// - computed vector latched into readable capture register when taken
// - multi vector mode: source priority bits change the vector address only by ranking which vector number wins
// - failed vector fetch requests system reset and clears violation flag
// - fetch fails outside executable flash; storage area excluded when enabled
// - locked bit blocks base writes; changing it needs the unlock sequence
// - bit change accepted only after 55h then AAh to lock register
// - one-shot mode: lock may be set once per reset and then not cleared
// - rank by user priority first, then natural order
// - user priorities apply only while priority scheme enabled
// - high beats low when pending, concurrent, or low routine running
// - equal priorities never preempt; natural order picks among them
// - preempted concurrent low request dropped if low enable cleared
// - preempted running low routine resumes regardless of low enable
// - natural order: vector 0 highest, lower number wins
// - global enables untouched by hardware; state machine tracks execution
module vap_ctrl
    import vap_pkg::*;
#(
    parameter int NUM_SRC = NSRC,
    parameter logic [ADDR_W-1:0] FLASH_SIZE = FLASH_BYTES,
    parameter logic [ADDR_W-1:0] SAF_SIZE = SAF_BYTES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [NUM_SRC-1:0] irq_flags,
    input wire logic [NUM_SRC-1:0] source_priority_bits,
    output logic irq_request,
    output logic irq_request_high,
    input wire logic core_take,
    input wire logic core_return,
    input wire logic fetch_valid,
    input wire logic [ENTRY_W-1:0] fetch_entry,
    output logic [ADDR_W-1:0] vector_address,
    output logic [VEC_W-1:0] vector_number,
    output logic [1:0] exec_state,
    output logic sys_reset_req
);
    // ======================================================
    // bus and register state
    logic wr_pend_q, wr_pend_d;
    logic [7:0] wr_addr_q, wr_addr_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic [CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [ADDR_W-1:0] base_q, base_d;
    logic [ADDR_W-1:0] capt_q, capt_d;
    logic locked_q, locked_d;
    logic oneshot_used_q, oneshot_used_d;
    vap_key_t key_q, key_d;
    logic memory_violation_flag_q, memory_violation_flag_d;
    vap_state_t state_q, state_d;
    logic [VEC_W-1:0] vec_q, vec_d;
    logic rst_req_q, rst_req_d;

    logic addr_phase;
    logic bus_wr;
    logic prio_en, high_global_enable, low_global_enable, mvec, saf_en;
    logic [NUM_SRC-1:0] hi_set, lo_set;
    logic hi_any, lo_any;
    logic [VEC_W-1:0] hi_idx, lo_idx;
    logic hi_ok, lo_ok, pick_high;
    logic [VEC_W-1:0] pick_idx;
    logic [ADDR_W-1:0] pick_addr;
    logic [ADDR_W-1:0] isr_addr;
    logic entry_bad, isr_bad, fault;

    assign prio_en = ctrl_q[CTRL_PRIO_EN];
    assign high_global_enable = ctrl_q[CTRL_HIGH_GLOBAL_ENABLE];
    assign low_global_enable = ctrl_q[CTRL_LOW_GLOBAL_ENABLE];
    assign mvec = ctrl_q[CTRL_MVEC];
    assign saf_en = ctrl_q[CTRL_SAF];

    // ======================================================
    // executable flash check
    function automatic logic not_exec(input logic [ADDR_W-1:0] a, input logic saf);
        logic outside;
        outside = (a >= FLASH_SIZE);
        if (saf && (a >= FLASH_SIZE - SAF_SIZE)) begin
            outside = 1'b1;
        end
        return outside;
    endfunction : not_exec

    // ======================================================
    // priority resolution
    always_comb begin
        if (prio_en) begin
            hi_set = irq_flags & source_priority_bits;
            lo_set = irq_flags & ~source_priority_bits;
        end else begin
            hi_set = irq_flags;
            lo_set = '0;
        end
    end

    vap_first #(.N(NUM_SRC), .W(VEC_W)) u_first_hi (
        .req(hi_set),
        .any(hi_any),
        .idx(hi_idx)
    );

    vap_first #(.N(NUM_SRC), .W(VEC_W)) u_first_lo (
        .req(lo_set),
        .any(lo_any),
        .idx(lo_idx)
    );

    assign hi_ok = high_global_enable & hi_any;
    assign lo_ok = prio_en & high_global_enable & low_global_enable & lo_any;

    always_comb begin
        irq_request = 1'b0;
        pick_high = 1'b0;
        case (state_q)
            VAP_MAIN: begin
                irq_request = hi_ok | lo_ok;
                pick_high = hi_ok;
            end
            VAP_LOW: begin
                irq_request = hi_ok;
                pick_high = 1'b1;
            end
            default: begin
                irq_request = 1'b0;
                pick_high = 1'b0;
            end
        endcase
    end
    assign irq_request_high = irq_request & pick_high;
    assign pick_idx = pick_high ? hi_idx : lo_idx;

    // ======================================================
    // vector address; source priority bits only pick high or low vector in single vector mode
    always_comb begin
        if (mvec) begin
            pick_addr = base_q + {{(ADDR_W-VEC_W-1){1'b0}}, pick_idx, 1'b0};
        end else if (pick_high) begin
            pick_addr = base_q;
        end else begin
            pick_addr = base_q + LOW_OFFSET;
        end
    end

    assign isr_addr = ADDR_W'({fetch_entry, 2'b00});
    assign entry_bad = not_exec(pick_addr, saf_en) | not_exec(pick_addr | 21'h000001, saf_en);
    assign isr_bad = not_exec(isr_addr, saf_en);
    assign fault = (core_take & irq_request & entry_bad) | (fetch_valid & isr_bad);

    // ======================================================
    // execution state, global enables left alone
    always_comb begin
        state_d = state_q;
        capt_d = capt_q;
        vec_d = vec_q;
        if (core_take && irq_request) begin
            capt_d = pick_addr;
            vec_d = pick_idx;
            if (state_q == VAP_LOW) begin
                state_d = VAP_HIGH_OVER_LOW;
            end else if (pick_high) begin
                state_d = VAP_HIGH;
            end else begin
                state_d = VAP_LOW;
            end
        end else if (core_return) begin
            case (state_q)
                VAP_HIGH_OVER_LOW: state_d = VAP_LOW;
                VAP_HIGH: state_d = VAP_MAIN;
                VAP_LOW: state_d = VAP_MAIN;
                default: state_d = VAP_MAIN;
            endcase
        end
        rst_req_d = fault;
    end

    // ======================================================
    // bus slave
    assign addr_phase = hsel & htrans[1] & hready;
    assign bus_wr = wr_pend_q;

    always_comb begin
        wr_pend_d = addr_phase & hwrite;
        wr_addr_d = addr_phase ? haddr : wr_addr_q;
        hrdata_d = 32'h00000000;
        if (addr_phase && !hwrite) begin
            if (haddr == OFS_CTRL) begin
                hrdata_d = 32'(ctrl_q);
            end else if (haddr == OFS_BASE) begin
                hrdata_d = 32'(base_q);
            end else if (haddr == OFS_LOCK) begin
                hrdata_d = 32'(locked_q) << LOCK_BIT;
            end else if (haddr == OFS_CAPT) begin
                hrdata_d = 32'(capt_q);
            end else if (haddr == OFS_PWR) begin
                hrdata_d = 32'(memory_violation_flag_q) << PWR_MEMORY_VIOLATION_FLAG;
            end else if (haddr == OFS_STAT) begin
                hrdata_d = (32'(state_q) << STAT_STATE_LSB) | (32'(vec_q) << STAT_VEC_LSB);
            end
        end
    end

    // ======================================================
    // register writes and lock sequence
    always_comb begin
        ctrl_d = ctrl_q;
        base_d = base_q;
        locked_d = locked_q;
        oneshot_used_d = oneshot_used_q;
        key_d = key_q;
        memory_violation_flag_d = memory_violation_flag_q;
        if (bus_wr) begin
            key_d = VAP_KEY_IDLE;
            if (wr_addr_q == OFS_CTRL) begin
                ctrl_d = hwdata[CTRL_W-1:0];
            end else if (wr_addr_q == OFS_BASE) begin
                if (!locked_q) begin
                    base_d = hwdata[ADDR_W-1:0];
                end
            end else if (wr_addr_q == OFS_LOCK) begin
                if (key_q == VAP_KEY_IDLE && hwdata[7:0] == UNLOCK_KEY1) begin
                    key_d = VAP_KEY_ONE;
                end else if (key_q == VAP_KEY_ONE && hwdata[7:0] == UNLOCK_KEY2) begin
                    key_d = VAP_KEY_TWO;
                end else if (key_q == VAP_KEY_TWO) begin
                    if (!(ctrl_q[CTRL_ONESHOT] && oneshot_used_q)) begin
                        locked_d = hwdata[LOCK_BIT];
                        if (ctrl_q[CTRL_ONESHOT] && hwdata[LOCK_BIT] && !locked_q) begin
                            oneshot_used_d = 1'b1;
                        end
                    end
                end
            end else if (wr_addr_q == OFS_PWR) begin
                memory_violation_flag_d = hwdata[PWR_MEMORY_VIOLATION_FLAG];
            end
        end
        if (fault) begin
            memory_violation_flag_d = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata_q <= 32'h00000000;
            ctrl_q <= CTRL_RESET;
            base_q <= BASE_RESET;
            capt_q <= 21'h000000;
            locked_q <= 1'b0;
            oneshot_used_q <= 1'b0;
            key_q <= VAP_KEY_IDLE;
            memory_violation_flag_q <= MEMORY_VIOLATION_FLAG_RESET;
            state_q <= VAP_MAIN;
            vec_q <= 7'h00;
            rst_req_q <= 1'b0;
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            hrdata_q <= hrdata_d;
            ctrl_q <= ctrl_d;
            base_q <= base_d;
            capt_q <= capt_d;
            locked_q <= locked_d;
            oneshot_used_q <= oneshot_used_d;
            key_q <= key_d;
            memory_violation_flag_q <= memory_violation_flag_d;
            state_q <= state_d;
            vec_q <= vec_d;
            rst_req_q <= rst_req_d;
        end
    end

    // ======================================================
    // outputs
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign vector_address = capt_q;
    assign vector_number = vec_q;
    assign exec_state = state_q;
    assign sys_reset_req = rst_req_q;

    logic unused_ok;
    assign unused_ok = ^hsize;
endmodule : vap_ctrl
`default_nettype wire

// file: inc/vap_pkg.sv
// ==========================================================
// vector, priority and lock constants
package vap_pkg;
    // ======================================================
    // sizes
    localparam int ADDR_W = 21;
    localparam int NSRC = 82;
    localparam int VEC_W = 7;
    localparam int ENTRY_W = 16;
    localparam logic [ADDR_W-1:0] FLASH_BYTES = 21'h010000;
    localparam logic [ADDR_W-1:0] SAF_BYTES = 21'h000080;

    // ======================================================
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_BASE = 8'h04;
    localparam logic [7:0] OFS_LOCK = 8'h08;
    localparam logic [7:0] OFS_CAPT = 8'h0c;
    localparam logic [7:0] OFS_PWR = 8'h10;
    localparam logic [7:0] OFS_STAT = 8'h14;

    // ======================================================
    // control fields
    localparam int CTRL_PRIO_EN = 0;
    localparam int CTRL_HIGH_GLOBAL_ENABLE = 1;
    localparam int CTRL_LOW_GLOBAL_ENABLE = 2;
    localparam int CTRL_MVEC = 3;
    localparam int CTRL_ONESHOT = 4;
    localparam int CTRL_SAF = 5;
    localparam int CTRL_W = 6;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;

    // ======================================================
    // other fields and values
    localparam int LOCK_BIT = 0;
    localparam int PWR_MEMORY_VIOLATION_FLAG = 0;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_VEC_LSB = 8;
    localparam logic [ADDR_W-1:0] BASE_RESET = 21'h000008;
    localparam logic [ADDR_W-1:0] LOW_OFFSET = 21'h000010;
    localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
    localparam logic MEMORY_VIOLATION_FLAG_RESET = 1'b1;

    // ======================================================
    // execution states
    typedef enum logic [1:0] {
        VAP_MAIN,
        VAP_LOW,
        VAP_HIGH,
        VAP_HIGH_OVER_LOW
    } vap_state_t;

    typedef enum logic [1:0] {
        VAP_KEY_IDLE,
        VAP_KEY_ONE,
        VAP_KEY_TWO
    } vap_key_t;
endpackage : vap_pkg

// file: rtl/vap_first.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// lowest set index wins
module vap_first #(
    parameter int N = 82,
    parameter int W = 7
) (
    input wire logic [N-1:0] req,
    output logic any,
    output logic [W-1:0] idx
);
    always_comb begin
        any = 1'b0;
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                any = 1'b1;
                idx = W'(i);
            end
        end
    end
endmodule : vap_first
`default_nettype wire

// file: tb/vap_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// port checker
module vap_ctrl_chk
    import vap_pkg::*;
#(
    parameter int NUM_SRC = NSRC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [NUM_SRC-1:0] irq_flags,
    input wire logic [NUM_SRC-1:0] source_priority_bits,
    input wire logic irq_request,
    input wire logic irq_request_high,
    input wire logic core_take,
    input wire logic core_return,
    input wire logic [VEC_W-1:0] vector_number,
    input wire logic [1:0] exec_state,
    input wire logic sys_reset_req
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic tk;
    assign tk = core_take && irq_request;
    take_high_a: assert property (tk && irq_request_high && exec_state == 2'h0
        |=> exec_state == 2'h2) else $error("high take did not enter high state");
    take_low_a: assert property (tk && !irq_request_high && exec_state == 2'h0
        |=> exec_state == 2'h1) else $error("low take did not enter low state");
    high_hold_a: assert property (exec_state[1] |-> !irq_request)
        else $error("request offered inside high routine");
    low_only_a: assert property (exec_state == 2'h1 && irq_request |-> irq_request_high)
        else $error("low request offered inside low routine");
    high_nest_a: assert property (tk && exec_state == 2'h1 |=> exec_state == 2'h3)
        else $error("high did not preempt low routine");
    resume_low_a: assert property (core_return && exec_state == 2'h3 |=> exec_state == 2'h1)
        else $error("low routine not resumed");
    fault_pulse_a: assert property (sys_reset_req |=> !sys_reset_req)
        else $error("reset request longer than one cycle");
    vec_hold_a: assert property (!tk |=> $stable(vector_number))
        else $error("vector number changed without take");
    natural_first_a: assert property (tk && irq_request_high && exec_state == 2'h0 && irq_flags[0]
        && source_priority_bits[0] |=> vector_number == 7'h00) else $error("vector 0 not first");
endmodule : vap_ctrl_chk
bind vap_ctrl vap_ctrl_chk #(.NUM_SRC(NUM_SRC)) chk_u (.hclk, .hresetn, .irq_flags,
    .source_priority_bits, .irq_request, .irq_request_high, .core_take, .core_return,
    .vector_number, .exec_state, .sys_reset_req);
`default_nettype wire

// file: tb/vap_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// core side model
module vap_core_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic irq_request,
    input wire logic [2:0] go,
    input wire logic [15:0] go_entry,
    output logic core_take,
    output logic core_return,
    output logic fetch_valid,
    output logic [15:0] fetch_entry
);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            core_take <= 1'b0;
            core_return <= 1'b0;
            fetch_valid <= 1'b0;
            fetch_entry <= 16'h0000;
        end else begin
            core_take <= go[0] && irq_request;
            core_return <= go[1];
            fetch_valid <= go[2];
            // entry not held outside its pulse
            fetch_entry <= go[2] ? go_entry : ~fetch_entry;
        end
    end
endmodule : vap_core_model
`default_nettype wire

// file: tb/vector_address_priority_lock_test.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// bench top
module vector_address_priority_lock_test;
    import vap_pkg::*;
    localparam logic [NSRC-1:0] ONE = 1;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0, rd;
    logic [NSRC-1:0] irq_flags = '0, source_priority_bits = '0;
    logic [2:0] go = 3'h0;
    logic [15:0] go_entry = 16'h0000;
    wire logic hreadyout, hresp, irq_request, irq_request_high, core_take, core_return;
    wire logic fetch_valid, sys_reset_req;
    wire logic [31:0] hrdata;
    wire logic [15:0] fetch_entry;
    wire logic [ADDR_W-1:0] vector_address;
    wire logic [VEC_W-1:0] vector_number;
    wire logic [1:0] exec_state;
    int fails = 0, checked = 0, cyc = 0, pulses = 0;
    vap_ctrl dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq_flags, .source_priority_bits,
        .irq_request, .irq_request_high, .core_take, .core_return, .fetch_valid, .fetch_entry,
        .vector_address, .vector_number, .exec_state, .sys_reset_req);
    vap_core_model core_u (.hclk, .hresetn, .irq_request, .go, .go_entry, .core_take,
        .core_return, .fetch_valid, .fetch_entry);
    initial forever #4 hclk = ~hclk;
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (sys_reset_req === 1'b1) begin
            pulses <= pulses + 1;
        end
        if (cyc == 3000) begin
            fails++;
            close_out();
        end
    end
    // ==========
    // tasks
    task close_out;
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rchk
    task core(input logic [2:0] g, input logic [15:0] e);
        go <= g;
        go_entry <= e;
        @(posedge hclk);
        go <= 3'h0;
        repeat (3) @(posedge hclk);
    endtask : core
    task keys(input logic [31:0] v);
        bus(1'b1, OFS_LOCK, 32'h55);
        bus(1'b1, OFS_LOCK, 32'haa);
        bus(1'b1, OFS_LOCK, v);
    endtask : keys
    task st(input logic [31:0] va, input logic [1:0] s);
        chk(32'(vector_address), va);
        chk(32'(exec_state), 32'(s));
    endtask : st
    // ==========
    // tests
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(OFS_BASE, 32'h8);
        rchk(OFS_CTRL, 32'h0);
        rchk(OFS_LOCK, 32'h0);
        rchk(OFS_PWR, 32'h1);
        rchk(8'h18, 32'h0);
        $display("test 1 done");
        bus(1'b1, OFS_CTRL, 32'h06);
        irq_flags <= ONE << 5;
        core(3'h1, 16'h0);
        st(32'h8, 2'h2);
        core(3'h2, 16'h0);
        chk(32'(irq_request_high), 32'h1);
        bus(1'b1, OFS_CTRL, 32'h07);
        source_priority_bits <= ONE << 5;
        core(3'h1, 16'h0);
        st(32'h8, 2'h2);
        source_priority_bits <= '0;
        core(3'h2, 16'h0);
        chk(32'(irq_request), 32'h1);
        chk(32'(irq_request_high), 32'h0);
        core(3'h1, 16'h0);
        st(32'h18, 2'h1);
        irq_flags <= '0;
        core(3'h2, 16'h0);
        $display("test 2 done");
        keys(32'h1);
        rchk(OFS_LOCK, 32'h1);
        bus(1'b1, OFS_BASE, 32'h100);
        rchk(OFS_BASE, 32'h8);
        bus(1'b1, OFS_LOCK, 32'h55);
        bus(1'b1, OFS_CTRL, 32'h0);
        bus(1'b1, OFS_LOCK, 32'haa);
        bus(1'b1, OFS_LOCK, 32'h0);
        rchk(OFS_LOCK, 32'h1);
        keys(32'h0);
        bus(1'b1, OFS_BASE, 32'h100);
        rchk(OFS_BASE, 32'h100);
        $display("test 3 done");
        bus(1'b1, OFS_CTRL, 32'h0f);
        source_priority_bits <= ~(ONE << 2);
        irq_flags <= (ONE << 3) | (ONE << 9);
        core(3'h1, 16'h0);
        chk(32'(vector_number), 32'h3);
        rchk(OFS_CAPT, 32'h106);
        rchk(OFS_CTRL, 32'h0f);
        core(3'h2, 16'h0);
        irq_flags <= (ONE << 2) | (ONE << 40);
        core(3'h1, 16'h0);
        st(32'h150, 2'h2);
        irq_flags <= ONE << 2;
        bus(1'b1, OFS_CTRL, 32'h0b);
        core(3'h2, 16'h0);
        chk(32'(irq_request), 32'h0);
        bus(1'b1, OFS_CTRL, 32'h0f);
        core(3'h1, 16'h0);
        st(32'h104, 2'h1);
        irq_flags <= ONE << 40;
        core(3'h1, 16'h0);
        st(32'h150, 2'h3);
        irq_flags <= '0;
        bus(1'b1, OFS_CTRL, 32'h0b);
        core(3'h2, 16'h0);
        chk(32'(exec_state), 32'h1);
        core(3'h2, 16'h0);
        irq_flags <= ONE | (ONE << 7);
        core(3'h1, 16'h0);
        st(32'h100, 2'h2);
        chk(32'(vector_number), 32'h0);
        irq_flags <= '0;
        core(3'h2, 16'h0);
        $display("test 4 done");
        bus(1'b1, OFS_CTRL, 32'h1f);
        irq_flags <= ONE << 3;
        core(3'h1, 16'h0);
        core(3'h4, 16'hffff);
        rchk(OFS_PWR, 32'h0);
        chk(32'(pulses), 32'h1);
        irq_flags <= '0;
        core(3'h2, 16'h0);
        bus(1'b1, OFS_PWR, 32'h1);
        core(3'h4, 16'h3fe0);
        rchk(OFS_PWR, 32'h1);
        bus(1'b1, OFS_CTRL, 32'h3f);
        core(3'h4, 16'h3fe0);
        rchk(OFS_PWR, 32'h0);
        chk(32'(pulses), 32'h2);
        keys(32'h1);
        keys(32'h0);
        rchk(OFS_LOCK, 32'h1);
        $display("test 5 done");
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(OFS_BASE, 32'h8);
        bus(1'b1, OFS_CTRL, 32'h10);
        keys(32'h1);
        rchk(OFS_LOCK, 32'h1);
        keys(32'h0);
        rchk(OFS_LOCK, 32'h1);
        $display("test 6 done");
        close_out();
    end
endmodule : vector_address_priority_lock_test
`default_nettype wire
